// ---- verilog/pmsr_pkg.sv ----
// constants, types and state layout of the phy management status registers
// assumes one clk_sys domain; mdc and mdio arrive unsynchronised from pins
package pmsr_pkg;

  // ---------------------------------------------
  // register map and fields
  // ---------------------------------------------
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_STATUS      = 5'h01;
  localparam logic [4:0]  REG_ID_HI       = 5'h02;
  localparam logic [4:0]  REG_ID_LO       = 5'h03;
  localparam logic [4:0]  REG_OFFER       = 5'h04;
  localparam logic [4:0]  REG_PARTNER     = 5'h05;
  localparam int          CTL_NEG_EN_BIT  = 12;
  localparam int          CTL_RESTART_BIT = 9;
  localparam int          ST_DONE_BIT     = 5;
  localparam int          ST_FAULT_BIT    = 4;
  localparam int          ST_LINK_BIT     = 2;
  localparam int          AB_PAUSE_BIT    = 10;
  localparam int          AB_RSV_BIT      = 9;
  localparam int          AB_LSB          = 5;
  localparam int          AB_MSB          = 8;
  localparam logic [15:0] STATUS_FIXED    = 16'h7808;
  localparam logic [15:0] OFFER_FIXED     = 16'h0801;
  localparam logic [15:0] PARTNER_FIXED   = 16'h0001;
  localparam logic [15:0] ZERO_WORD       = 16'h0000;
  localparam logic [3:0]  ABIL_RESET      = 4'hF;

  // ---------------------------------------------
  // management frame
  // ---------------------------------------------
  localparam logic [5:0]  PRE_MIN   = 6'h20;
  localparam logic [4:0]  HDR_LAST  = 5'h0D;
  localparam logic [4:0]  TA_LAST   = 5'h01;
  localparam logic [4:0]  DATA_LAST = 5'h0F;
  localparam logic [1:0]  FR_START  = 2'h1;
  localparam logic [1:0]  OP_WRITE  = 2'h1;
  localparam logic [1:0]  OP_READ   = 2'h2;

  typedef enum logic [2:0] {
    PMSR_IDLE = 3'b000,
    PMSR_HDR  = 3'b001,
    PMSR_TA   = 3'b010,
    PMSR_WDAT = 3'b011,
    PMSR_RDAT = 3'b100
  } pmsr_state_t;

  typedef struct packed {
    logic link_up;
    logic far_fault;
    logic neg_done;
  } pmsr_core_t;

  typedef struct packed {
    logic       pause;
    logic [3:0] abil;
  } pmsr_offer_t;

  typedef struct packed {
    logic        mdc_s1;
    logic        mdc_s2;
    logic        mdc_l;
    logic        md_s1;
    logic        md_s2;
    pmsr_state_t st;
    logic [5:0]  pre_cnt;
    logic [4:0]  cnt;
    logic [13:0] hdr;
    logic [15:0] rd;
    logic [4:0]  wr_reg;
    logic        is_wr;
    logic        mdo;
    logic        mdoe;
    logic        neg_en;
    logic        restart;
    pmsr_offer_t offer;
    logic        adv_rsv;
    logic        link;
    logic        fault;
    logic        done;
    pmsr_offer_t partner;
  } pmsr_reg_t;

endpackage

// ---- verilog/pmsr_regs.sv ----
// management register set of one copper phy port, reached over mdc/mdio
// assumes phy core signals on clk_sys; mdc/mdio pins are asynchronous
`timescale 1ns/1ns
module pmsr_regs #(
  parameter logic [4:0]  PHY_ADDR  = 5'h01,
  parameter logic [15:0] PHY_ID_HI = 16'h1234, // value arbitrary
  parameter logic [15:0] PHY_ID_LO = 16'h5678  // value arbitrary
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 mdc,
  input  wire logic                 mdio_in,
  output logic                      mdio_out,
  output logic                      mdio_oe,
  input  wire pmsr_pkg::pmsr_core_t core_status,
  input  wire logic [15:0]          partner_page,
  output logic                      negotiation_enable,
  output logic                      negotiation_restart,
  output pmsr_pkg::pmsr_offer_t     offer
);
  import pmsr_pkg::*;

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  pmsr_reg_t   s_q;
  pmsr_reg_t   s_d;
  logic        rise;
  logic        md;
  logic [13:0] hdr_n;
  logic [15:0] wr_data;
  logic [15:0] ctrl_w;
  logic [15:0] status_w;
  logic [15:0] offer_w;
  logic [15:0] partner_w;
  logic [15:0] rd_word;
  logic        hdr_end;
  logic        hdr_ok;
  logic        wr_go;
  logic        done_rise;

  // ---------------------------------------------
  // register words as read
  // ---------------------------------------------
  always_comb begin
    ctrl_w                   = ZERO_WORD;
    ctrl_w[CTL_NEG_EN_BIT]   = s_q.neg_en;
    status_w                 = STATUS_FIXED;
    status_w[ST_DONE_BIT]    = s_q.done;
    status_w[ST_FAULT_BIT]   = s_q.fault;
    status_w[ST_LINK_BIT]    = s_q.link;
    offer_w                  = OFFER_FIXED;
    offer_w[AB_PAUSE_BIT]    = s_q.offer.pause;
    offer_w[AB_RSV_BIT]      = s_q.adv_rsv;
    offer_w[AB_MSB:AB_LSB]   = s_q.offer.abil;
    partner_w                = PARTNER_FIXED;
    partner_w[AB_PAUSE_BIT]  = s_q.partner.pause;
    partner_w[AB_MSB:AB_LSB] = s_q.partner.abil;
  end

  // ---------------------------------------------
  // frame decode helpers
  // ---------------------------------------------
  assign rise      = s_q.mdc_s2 & ~s_q.mdc_l;
  assign md        = s_q.md_s2;
  assign hdr_n     = {s_q.hdr[12:0], md};
  assign wr_data   = {s_q.rd[14:0], md};
  assign hdr_end   = rise && (s_q.st == PMSR_HDR) && (s_q.cnt == HDR_LAST);
  assign hdr_ok    = (hdr_n[13:12] == FR_START) && (hdr_n[9:5] == PHY_ADDR)
                     && ((hdr_n[11:10] == OP_READ) || (hdr_n[11:10] == OP_WRITE));
  assign wr_go     = rise && (s_q.st == PMSR_WDAT) && (s_q.cnt == DATA_LAST);
  assign done_rise = core_status.neg_done & ~s_q.done;

  always_comb begin
    unique case (hdr_n[4:0])
      REG_CTRL:    rd_word = ctrl_w;
      REG_STATUS:  rd_word = status_w;
      REG_ID_HI:   rd_word = PHY_ID_HI;
      REG_ID_LO:   rd_word = PHY_ID_LO;
      REG_OFFER:   rd_word = offer_w;
      REG_PARTNER: rd_word = partner_w;
      default:     rd_word = ZERO_WORD;
    endcase
  end

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.mdc_s1  = mdc;
    s_d.mdc_s2  = s_q.mdc_s1;
    s_d.mdc_l   = s_q.mdc_s2;
    s_d.md_s1   = mdio_in;
    s_d.md_s2   = s_q.md_s1;
    s_d.restart = 1'b0;
    s_d.link    = core_status.link_up;
    s_d.fault   = core_status.far_fault;
    s_d.done    = core_status.neg_done;
    if (rise) begin
      unique case (s_q.st)
        PMSR_IDLE: begin
          if (md) begin
            if (s_q.pre_cnt != PRE_MIN) begin
              s_d.pre_cnt = s_q.pre_cnt + 6'h01;
            end
          end else if (s_q.pre_cnt == PRE_MIN) begin
            s_d.st  = PMSR_HDR;
            s_d.hdr = hdr_n;
            s_d.cnt = 5'h01;
          end else begin
            s_d.pre_cnt = 6'h00;
          end
        end
        PMSR_HDR: begin
          s_d.hdr = hdr_n;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == HDR_LAST) begin
            s_d.cnt     = 5'h00;
            s_d.pre_cnt = 6'h00;
            s_d.wr_reg  = hdr_n[4:0];
            s_d.is_wr   = (hdr_n[11:10] == OP_WRITE);
            s_d.rd      = rd_word;
            s_d.st      = hdr_ok ? PMSR_TA : PMSR_IDLE;
          end
        end
        PMSR_TA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (!s_q.is_wr && (s_q.cnt == 5'h00)) begin
            s_d.mdoe = 1'b1;
            s_d.mdo  = 1'b0;
          end
          if (s_q.cnt == TA_LAST) begin
            s_d.cnt = 5'h00;
            if (s_q.is_wr) begin
              s_d.st = PMSR_WDAT;
            end else begin
              s_d.st  = PMSR_RDAT;
              s_d.mdo = s_q.rd[15];
              s_d.rd  = {s_q.rd[14:0], 1'b0};
            end
          end
        end
        PMSR_WDAT: begin
          s_d.rd  = wr_data;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == DATA_LAST) begin
            s_d.st = PMSR_IDLE;
          end
        end
        PMSR_RDAT: begin
          s_d.cnt = s_q.cnt + 5'h01;
          s_d.mdo = s_q.rd[15];
          s_d.rd  = {s_q.rd[14:0], 1'b0};
          if (s_q.cnt == DATA_LAST) begin
            s_d.st   = PMSR_IDLE;
            s_d.mdoe = 1'b0;
            s_d.mdo  = 1'b0;
          end
        end
        default: begin
          s_d.st   = PMSR_IDLE;
          s_d.mdoe = 1'b0;
        end
      endcase
    end
    // register writes; read-only registers and fields take nothing
    if (wr_go) begin
      if (s_q.wr_reg == REG_CTRL) begin
        s_d.neg_en  = wr_data[CTL_NEG_EN_BIT];
        s_d.restart = wr_data[CTL_RESTART_BIT];
      end
      if (s_q.wr_reg == REG_OFFER) begin
        s_d.offer.pause = wr_data[AB_PAUSE_BIT];
        s_d.adv_rsv     = wr_data[AB_RSV_BIT];
        s_d.offer.abil  = wr_data[AB_MSB:AB_LSB];
      end
    end
    // partner page: cleared on restart, loaded on completion, load wins
    if (s_q.restart) begin
      s_d.partner = '0;
    end
    if (done_rise) begin
      s_d.partner.pause = partner_page[AB_PAUSE_BIT];
      s_d.partner.abil  = partner_page[AB_MSB:AB_LSB];
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q             <= '0;
      s_q.st          <= PMSR_IDLE;
      s_q.neg_en      <= 1'b1;
      s_q.offer.pause <= 1'b1;
      s_q.offer.abil  <= ABIL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_out            = s_q.mdo;
  assign mdio_oe             = s_q.mdoe;
  assign negotiation_enable  = s_q.neg_en;
  assign negotiation_restart = s_q.restart;
  assign offer               = s_q.offer;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------
  // status word checks
  // ---------------------------------------------
  no_four_pair_a: assert property (status_w[15] == 1'b0)
    else $error("status bit 15 not zero");
  abil_ones_a: assert property (status_w[14:11] == 4'hF)
    else $error("status ability bits not all set");
  done_track_a: assert property (core_status.neg_done |=> status_w[ST_DONE_BIT])
    else $error("negotiation done not reported");
  fault_track_a: assert property (!core_status.far_fault |=> !status_w[ST_FAULT_BIT])
    else $error("fault shown without cause");
  neg_capable_a: assert property (status_w[3] && !status_w[0])
    else $error("capability bits wrong");
  link_track_a: assert property ($rose(core_status.link_up) |=> status_w[ST_LINK_BIT])
    else $error("link up not reported");
  fault_set_a: assert property (core_status.far_fault |=> status_w[ST_FAULT_BIT])
    else $error("fault not reported");
  done_clear_a: assert property (!core_status.neg_done |=> !status_w[ST_DONE_BIT])
    else $error("negotiation done shown early");
  link_fall_a: assert property (!core_status.link_up |=> !status_w[ST_LINK_BIT])
    else $error("link down not reported");
  status_read_a: assert property (hdr_end && hdr_n[4:0] == REG_STATUS |=>
      s_q.rd[15:11] == 5'h0F && s_q.rd[0] == 1'b0)
    else $error("status fixed bits wrong in read");

  // ---------------------------------------------
  // identifier and offer checks
  // ---------------------------------------------
  ident_load_a: assert property (hdr_end && hdr_n[4:0] == REG_ID_HI |=> s_q.rd == PHY_ID_HI)
    else $error("identifier upper word wrong");
  ident_lower_a: assert property (hdr_end && hdr_n[4:0] == REG_ID_LO |=>
      s_q.rd == PHY_ID_LO)
    else $error("identifier lower word wrong");
  selector_read_a: assert property (hdr_end && hdr_n[4:0] == REG_OFFER |=>
      s_q.rd[4:0] == 5'h01)
    else $error("selector wrong in read");
  offer_write_a: assert property (wr_go && s_q.wr_reg == REG_OFFER |=>
      offer == {$past(wr_data[AB_PAUSE_BIT]), $past(wr_data[AB_MSB:AB_LSB])})
    else $error("offer write not applied");
  offer_fixed_a: assert property (offer_w[4:0] == 5'h01 && offer_w[15:11] == 5'h01)
    else $error("offer fixed fields altered");
  offer_hold_a: assert property (!(wr_go && s_q.wr_reg == REG_OFFER) |=>
      $stable(offer))
    else $error("offer changed without write");

  // ---------------------------------------------
  // partner and control checks
  // ---------------------------------------------
  partner_load_a: assert property (done_rise |=>
      partner_w[AB_PAUSE_BIT:AB_LSB] == {$past(partner_page[AB_PAUSE_BIT]), 1'b0,
                                          $past(partner_page[AB_MSB:AB_LSB])})
    else $error("partner page not captured");
  restart_pulse_a: assert property (wr_go && s_q.wr_reg == REG_CTRL
      && wr_data[CTL_RESTART_BIT] |=> negotiation_restart ##1 !negotiation_restart)
    else $error("restart not a single pulse");
  enable_write_a: assert property (wr_go && s_q.wr_reg == REG_CTRL |=>
      negotiation_enable == $past(wr_data[CTL_NEG_EN_BIT]))
    else $error("enable write not applied");
  status_ro_a: assert property (wr_go && s_q.wr_reg == REG_STATUS |=>
      $stable(offer) && $stable(negotiation_enable))
    else $error("status write changed state");
  partner_ro_a: assert property (wr_go && s_q.wr_reg == REG_PARTNER && !done_rise
      && !s_q.restart |=> $stable(partner_w))
    else $error("partner write changed state");
  partner_read_a: assert property (hdr_end && hdr_n[4:0] == REG_PARTNER |=>
      s_q.rd[4:0] == 5'h01 && s_q.rd[15:11] == 5'h00 && s_q.rd[9] == 1'b0)
    else $error("partner reserved bits wrong in read");
  restart_clear_a: assert property (s_q.restart && !done_rise |=>
      partner_w[AB_PAUSE_BIT:AB_LSB] == 6'h00)
    else $error("partner fields not cleared");
  enable_hold_a: assert property (!(wr_go && s_q.wr_reg == REG_CTRL) |=>
      $stable(negotiation_enable))
    else $error("enable changed without write");
  restart_only_a: assert property (!(wr_go && s_q.wr_reg == REG_CTRL
      && wr_data[CTL_RESTART_BIT]) |=> !negotiation_restart)
    else $error("restart without write");

  // ---------------------------------------------
  // coverage
  // ---------------------------------------------

  read_frame_c: cover property (s_q.st == PMSR_RDAT && s_q.cnt == DATA_LAST && rise);
  write_frame_c: cover property (wr_go && s_q.wr_reg == REG_OFFER);
  partner_cap_c: cover property (done_rise && partner_page[AB_PAUSE_BIT]);
  refused_frame_c: cover property (hdr_end && !hdr_ok);
  restart_clear_c: cover property (s_q.restart && !done_rise);

endmodule

// ---- verif/pmsr_mgr.sv ----
// station management controller model: mdc/mdio frames
// assumes a pull-up on mdio and a block that answers on mdc rising edges
`timescale 1ns/1ns
module pmsr_mgr (
  output logic      mdc,
  output logic      mdio_line,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic mo;
  logic moe;
  // wire level: block, then master, else pull-up
  assign mdio_line = mdio_oe ? mdio_out : (moe ? mo : 1'b1);
  initial begin
    mdc = 1'b0;
    mo = 1'b1;
    moe = 1'b0;
  end
  // one frame, 32-one preamble, 80 ns mdc, idle low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [64:0] w;
    w = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd, 1'b1};
    rd = 16'h0000;
    for (int j = 0; j < 65; j++) begin
      mo = w[64-j];
      moe = !(op == 2'b10 && j > 45) && j < 64;
      #40;
      if (j > 47 && j < 64) rd = {rd[14:0], mdio_line};
      mdc = 1'b1;
      #40;
      mdc = 1'b0;
    end
  endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench of the phy management status registers
// assumes pmsr_mgr as management controller; core inputs driven here
`timescale 1ns/1ns
module tb_top;
  import pmsr_pkg::*;
  localparam logic [15:0] ID_HI = 16'hA5C3; // value arbitrary
  localparam logic [15:0] ID_LO = 16'h3C5A; // value arbitrary
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        mdc;
  logic        mdio_line;
  logic        mdio_out;
  logic        mdio_oe;
  pmsr_core_t  core_status = '0;
  logic [15:0] partner_page = 16'h0000;
  logic        negotiation_enable;
  logic        negotiation_restart;
  pmsr_offer_t offer;
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_pulse = 0;
  logic [15:0] r;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (negotiation_restart === 1'b1) n_pulse++;
  pmsr_regs #(.PHY_ADDR(5'h01), .PHY_ID_HI(ID_HI), .PHY_ID_LO(ID_LO)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .core_status(core_status),
    .partner_page(partner_page), .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart), .offer(offer));
  pmsr_mgr u_mgr (.mdc(mdc), .mdio_line(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // frames start 1 ns after a clk_sys edge, keeping mdc edges off it
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd);
    @(posedge clk_sys);
    #1;
    u_mgr.frame(op, pa, ra, wd, r);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input string nm);
    xfer(OP_READ, 5'h01, ra, 16'h0000);
    chk(nm, e, r);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    xfer(OP_WRITE, 5'h01, ra, d);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic page(input logic [15:0] p);
    @(posedge clk_sys);
    #1;
    partner_page = p;
  endtask
  task automatic core(input logic [2:0] c);
    @(posedge clk_sys);
    #1;
    core_status = c;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    chk("enable", 16'h0001, {15'h0, negotiation_enable});
    chk("offer", 16'h001F, {11'h0, offer});
    rd(REG_STATUS, 16'h7808, "status");
    rd(REG_ID_HI, ID_HI, "id_hi");
    rd(REG_ID_LO, ID_LO, "id_lo");
    rd(REG_OFFER, 16'h0DE1, "offer_reg");
    rd(REG_PARTNER, 16'h0001, "partner");
    $display("test reset done");
  endtask
  task automatic t_status;
    logic [15:0] ev;
    for (int i = 0; i < 8; i++) begin
      core(i[2:0]);
      ev = 16'h7808 | {10'h0, i[0], i[1], 1'b0, i[2], 2'b00};
      rd(REG_STATUS, ev, "status");
    end
    core(3'b000);
    $display("test status done");
  endtask
  task automatic t_offer;
    logic [4:0] ro[4] = '{REG_STATUS, REG_ID_HI, REG_ID_LO, REG_PARTNER};
    logic [15:0] ev[4] = '{16'h7808, ID_HI, ID_LO, 16'h0001};
    wr(REG_OFFER, 16'hFFFF);
    chk("offer", 16'h001F, {11'h0, offer});
    rd(REG_OFFER, 16'h0FE1, "offer_reg");
    wr(REG_OFFER, 16'h0000);
    chk("offer", 16'h0000, {11'h0, offer});
    rd(REG_OFFER, 16'h0801, "offer_reg");
    for (int i = 0; i < 4; i++) begin
      wr(ro[i], ~ev[i]);
      rd(ro[i], ev[i], "ro_reg");
    end
    rd(5'h1F, 16'h0000, "unmapped");
    xfer(OP_READ, 5'h02, REG_STATUS, 16'h0000);
    chk("other_addr", 16'hFFFF, r);
    xfer(2'b11, 5'h01, REG_OFFER, 16'hFFFF);
    rd(REG_OFFER, 16'h0801, "bad_op");
    xfer(OP_WRITE, 5'h02, REG_OFFER, 16'hFFFF);
    rd(REG_OFFER, 16'h0801, "other_addr_wr");
    $display("test offer done");
  endtask
  task automatic t_partner;
    page(16'hFFFF);
    core(3'b001);
    rd(REG_PARTNER, 16'h05E1, "partner");
    page(16'h0000);
    rd(REG_PARTNER, 16'h05E1, "partner_held");
    core(3'b000);
    page(16'h0340);
    core(3'b001);
    rd(REG_PARTNER, 16'h0141, "partner");
    $display("test partner done");
  endtask
  task automatic t_ctrl;
    int p0;
    p0 = n_pulse;
    wr(REG_CTRL, 16'h0200);
    chk("restart_pulses", 16'h0001, 16'(n_pulse - p0));
    chk("enable", 16'h0000, {15'h0, negotiation_enable});
    rd(REG_CTRL, 16'h0000, "ctrl");
    rd(REG_PARTNER, 16'h0001, "partner_clr");
    wr(REG_CTRL, 16'h1000);
    chk("enable", 16'h0001, {15'h0, negotiation_enable});
    rd(REG_CTRL, 16'h1000, "ctrl");
    $display("test control done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_status();
    t_offer();
    t_partner();
    t_ctrl();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule
